/* File: did_cfg.svh */
// Bit positions and fixed encodings for the dual instruction set decoder.
// Assumes inclusion by bare name from the decoder.
`ifndef DID_CFG_SVH
`define DID_CFG_SVH
// Full-width word field positions
`define DID_COND_HI   31
`define DID_COND_LO   28
`define DID_I_BIT     25
`define DID_P_BIT     24
`define DID_U_BIT     23
`define DID_BN_BIT    22
`define DID_W_BIT     21
`define DID_SL_BIT    20
`define DID_OPC_HI    24
`define DID_OPC_LO    21
`define DID_RN_HI     19
`define DID_RN_LO     16
`define DID_RD_HI     15
`define DID_RD_LO     12
`define DID_ROT_HI    11
`define DID_ROT_LO    8
`define DID_IMM_HI    7
`define DID_IMM_LO    0
`define DID_CPN_HI    11
`define DID_CPN_LO    8
// Fixed patterns
`define DID_BX_PAT    24'h12fff1
`define DID_MUL_PAT   4'h9
`define DID_AL_COND   4'he
`define DID_UNDEF_WORD 32'he7f000f0
`define DID_SWI_HALF  8'hdf
`define DID_RESET_WORD 32'h00000000
`endif

/* File: did_decoder.sv */
// Decode stage for a core running a full 32-bit and a compact 16-bit set.
// Assumes fetch logic on ref_clk presents one word per valid cycle.
//
// Summary of operation
// - Decode full or compact set per state
// - Each supported halfword expands to one equivalent word; others give the undefined word
// - Expansion adds no cycle over full words
// - Compact forms use the same register file
// - Full 32-bit datapath kept in compact state
// - Immediate is 8 bits rotated right evenly
// - Translation option forces user-level, post-index only
// - Set-flags bit enables flag update only
// - Condition on top; fixed data fields below
// - Block words give control bits, base, list
// - Interrupt word low bits are ignored
// - Unassigned forms do not trap; unpredictable
`include "did_cfg.svh"
`default_nettype none
module did_decoder (
    // Clock and reset
    input  wire logic                ref_clk,
    input  wire logic                srst,
    // Fetched word and state
    input  wire logic                instr_valid,
    input  wire logic [31:0]         instr_word,
    input  wire logic                half_sel,
    input  wire logic                compact_state,
    input  wire logic [3:0]          cond_flags,
    // Decoded word and class
    output logic                     dec_valid,
    output did_pkg::did_class_t      dec_class,
    output logic [31:0]              expanded_word,
    output logic                     compact_unsupported,
    output logic                     cond_pass,
    output logic [3:0]               cond_field,
    // Data operand fields
    output logic [3:0]               opcode_field,
    output logic [3:0]               first_source_reg_field,
    output logic [3:0]               dest_reg_field,
    output logic                     imm_operand,
    output logic [31:0]              rotated_immediate,
    // Transfer fields
    output logic                     user_translate,
    output logic [4:0]               block_transfer_control_bits,
    output logic [15:0]              reg_list,
    output logic [3:0]               coproc_reg_field,
    output logic [3:0]               coproc_number_field,
    output logic [7:0]               coproc_offset,
    // Side effect enables
    output logic                     reg_write_en,
    output logic                     flags_write_en,
    output logic                     mem_access_en,
    output logic                     undef_trap,
    output logic                     unpredictable
);
    import did_pkg::*;

    // ----------------------------------------
    // Condition evaluation
    // ----------------------------------------
    // Flags ordered N Z C V from bit 3 down
    function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f);
        logic n;
        logic z;
        logic cy;
        logic v;
        n  = f[3];
        z  = f[2];
        cy = f[1];
        v  = f[0];
        case (did_cond_t'(c))
            DID_EQ:  cond_ok = z;
            DID_NE:  cond_ok = ~z;
            DID_CS:  cond_ok = cy;
            DID_CC:  cond_ok = ~cy;
            DID_MI:  cond_ok = n;
            DID_PL:  cond_ok = ~n;
            DID_VS:  cond_ok = v;
            DID_VC:  cond_ok = ~v;
            DID_HI:  cond_ok = cy & ~z;
            DID_LS:  cond_ok = ~cy | z;
            DID_GE:  cond_ok = (n == v);
            DID_LT:  cond_ok = (n != v);
            DID_GT:  cond_ok = ~z & (n == v);
            DID_LE:  cond_ok = z | (n != v);
            DID_AL:  cond_ok = 1'b1;
            default: cond_ok = 1'b0; // Reserved code never executes
        endcase
    endfunction

    // ----------------------------------------
    // Compact expansion
    // ----------------------------------------
    wire [15:0] hw   = half_sel ? instr_word[31:16] : instr_word[15:0]; // Halfword pick
    wire [2:0]  h_rd = hw[2:0];                    // Low destination
    wire [2:0]  h_rs = hw[5:3];                    // Low source
    wire [2:0]  h_r8 = hw[10:8];                   // Immediate-form register
    wire [3:0]  h_op = hw[9:6];                    // Register ALU op
    // Shift by immediate
    wire        f_sh  = (hw[15:13] == 3'b000) && (hw[12:11] != 2'b11);
    // Three-operand add and subtract
    wire        f_as  = (hw[15:11] == 5'b00011);
    // Move, compare, add, subtract immediate
    wire        f_imm = (hw[15:13] == 3'b001);
    // Register ALU ops that map one to one
    wire        alu_direct = (h_op == 4'h0) || (h_op == 4'h1) || (h_op == 4'h5) ||
                             (h_op == 4'h6) || (h_op == 4'h8) || (h_op == 4'ha) ||
                             (h_op == 4'hb) || (h_op == 4'hc) || (h_op == 4'he) ||
                             (h_op == 4'hf);
    wire        f_alu = (hw[15:10] == 6'b010000) && alu_direct;
    wire        f_swi = (hw[15:8] == `DID_SWI_HALF);
    // Opcodes chosen by the immediate form
    wire [3:0]  imm_opc = (hw[12:11] == 2'b00) ? 4'hd :
                          (hw[12:11] == 2'b01) ? 4'ha :
                          (hw[12:11] == 2'b10) ? 4'h4 : 4'h2;
    wire [3:0]  imm_rn  = (hw[12:11] == 2'b00) ? 4'h0 : {1'b0, h_r8};
    wire [3:0]  imm_rd  = (hw[12:11] == 2'b01) ? 4'h0 : {1'b0, h_r8};
    wire [3:0]  alu_rd  = (h_op[3:2] == 2'b10) ? 4'h0 : {1'b0, h_rd};
    wire [3:0]  alu_rn  = (h_op == 4'hf) ? 4'h0 : {1'b0, h_rd};
    // Equivalent full words, all but the interrupt setting flags as the compact form does
    wire [31:0] x_sh  = {`DID_AL_COND, 8'h1b, 4'h0, 1'b0, h_rd, hw[10:6],
                         hw[12:11], 1'b0, 1'b0, h_rs};
    wire [31:0] x_as  = {`DID_AL_COND, 2'b00, hw[10], (hw[9] ? 4'h2 : 4'h4), 1'b1,
                         1'b0, h_rs, 1'b0, h_rd, 9'h000, hw[8:6]};
    wire [31:0] x_imm = {`DID_AL_COND, 3'b001, imm_opc, 1'b1, imm_rn, imm_rd,
                         4'h0, hw[7:0]};
    wire [31:0] x_alu = {`DID_AL_COND, 3'b000, h_op, 1'b1, alu_rn, alu_rd,
                         8'h00, 1'b0, h_rs};
    wire [31:0] x_swi = {`DID_AL_COND, 4'hf, 16'h0000, hw[7:0]};
    wire        x_hit = f_sh | f_as | f_imm | f_alu | f_swi;
    // Pure combinational, so a compact word costs no extra cycle
    wire [31:0] x_word = f_sh  ? x_sh  :
                         f_as  ? x_as  :
                         f_imm ? x_imm :
                         f_alu ? x_alu :
                         f_swi ? x_swi : `DID_UNDEF_WORD;
    // Word fed to the one shared decode path
    wire [31:0] w = compact_state ? x_word : instr_word;

    // ----------------------------------------
    // Class decode
    // ----------------------------------------
    wire c_bx   = (w[27:4] == `DID_BX_PAT);
    wire c_mul  = (w[27:22] == 6'h00) && (w[7:4] == `DID_MUL_PAT);
    wire c_mull = (w[27:23] == 5'b00001) && (w[7:4] == `DID_MUL_PAT);
    wire c_swp  = (w[27:23] == 5'b00010) && (w[21:20] == 2'b00) &&
                  (w[11:4] == {4'h0, `DID_MUL_PAT});
    wire c_half = (w[27:25] == 3'b000) && w[7] && w[4] && (w[6:5] != 2'b00);
    wire c_und  = (w[27:25] == 3'b011) && w[4];
    wire c_sgl  = (w[27:26] == 2'b01) && !c_und;
    wire c_blk  = (w[27:25] == 3'b100);
    wire c_br   = (w[27:25] == 3'b101);
    wire c_cpx  = (w[27:25] == 3'b110);
    wire c_cpo  = (w[27:24] == 4'he) && !w[4];
    wire c_cpr  = (w[27:24] == 4'he) && w[4];
    wire c_swi  = (w[27:24] == 4'hf);
    wire c_dp   = (w[27:26] == 2'b00) && !(c_bx | c_mul | c_mull | c_swp | c_half);
    // Store forms with the signed bit set: no trap, behaviour undefined
    wire c_unp  = c_half && w[6] && !w[`DID_SL_BIT];
    // Priority encode of the class
    wire did_class_t next_class =
        c_bx   ? DID_BX     : c_mul  ? DID_MUL    : c_mull ? DID_MULL   :
        c_swp  ? DID_SWAP   : c_half ? DID_HALF   : c_dp   ? DID_DP     :
        c_und  ? DID_UNDEF  : c_sgl  ? DID_SINGLE : c_blk  ? DID_BLOCK  :
        c_br   ? DID_BRANCH : c_cpx  ? DID_CPXFER : c_cpo  ? DID_CPOP   :
        c_cpr  ? DID_CPREG  : DID_SWI;

    // ----------------------------------------
    // Field and enable decode
    // ----------------------------------------
    wire        next_pass = cond_ok(w[`DID_COND_HI:`DID_COND_LO], cond_flags);
    // Immediate built by even rotation of eight bits
    wire [4:0]  rot_amt = {w[`DID_ROT_HI:`DID_ROT_LO], 1'b0};
    wire [31:0] imm_base = {24'h000000, w[`DID_IMM_HI:`DID_IMM_LO]};
    wire [63:0] imm_dbl  = {imm_base, imm_base} >> rot_amt;
    wire [31:0] next_rot = imm_dbl[31:0];
    // Forced user translation: post-indexed single transfer with W set
    wire next_user = c_sgl && !w[`DID_P_BIT] && w[`DID_W_BIT];
    // Test and compare ops write no register
    wire dp_wr  = c_dp && (w[`DID_OPC_HI:`DID_OPC_HI-1] != 2'b10);
    wire ls_wr  = (c_half | c_sgl | c_blk) &&
                  (w[`DID_SL_BIT] | w[`DID_W_BIT] | !w[`DID_P_BIT]);
    wire any_wr = dp_wr | c_mul | c_mull | c_swp | ls_wr |
                  (c_cpx & w[`DID_W_BIT]) | (c_br & w[`DID_P_BIT]) |
                  (c_cpr & w[`DID_SL_BIT]);
    wire any_mem = (c_swp | c_half | c_sgl | c_blk | c_cpx) && !c_unp;
    // Flag update only with the set-flags bit on a data or multiply op
    wire next_fwe = next_pass && w[`DID_SL_BIT] && (c_dp | c_mul | c_mull);
    // Interrupt words carry no operand fields
    wire [3:0] next_rn = c_swi ? 4'h0 : w[`DID_RN_HI:`DID_RN_LO];
    wire [3:0] next_rd = c_swi ? 4'h0 : w[`DID_RD_HI:`DID_RD_LO];

    // ----------------------------------------
    // Output registers
    // ----------------------------------------
    // Class, word and condition
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            dec_valid           <= 1'b0;
            dec_class           <= DID_DP;
            expanded_word       <= `DID_RESET_WORD;
            compact_unsupported <= 1'b0;
            cond_pass           <= 1'b0;
            cond_field          <= 4'h0;
        end else begin
            dec_valid           <= instr_valid;
            dec_class           <= next_class;
            expanded_word       <= w;
            compact_unsupported <= instr_valid && compact_state && !x_hit;
            cond_pass           <= next_pass;
            cond_field          <= w[`DID_COND_HI:`DID_COND_LO];
        end
    end

    // Operand and transfer fields
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            opcode_field                <= 4'h0;
            first_source_reg_field      <= 4'h0;
            dest_reg_field              <= 4'h0;
            imm_operand                 <= 1'b0;
            rotated_immediate           <= 32'h00000000;
            user_translate              <= 1'b0;
            block_transfer_control_bits <= 5'h00;
            reg_list                    <= 16'h0000;
            coproc_reg_field            <= 4'h0;
            coproc_number_field         <= 4'h0;
            coproc_offset               <= 8'h00;
        end else begin
            opcode_field                <= w[`DID_OPC_HI:`DID_OPC_LO];
            first_source_reg_field      <= next_rn;
            dest_reg_field              <= next_rd;
            imm_operand                 <= c_dp && w[`DID_I_BIT];
            rotated_immediate           <= next_rot;
            user_translate              <= next_user;
            block_transfer_control_bits <= w[`DID_P_BIT:`DID_SL_BIT];
            reg_list                    <= w[15:0];
            coproc_reg_field            <= w[`DID_RD_HI:`DID_RD_LO];
            coproc_number_field         <= w[`DID_CPN_HI:`DID_CPN_LO];
            coproc_offset               <= w[`DID_IMM_HI:`DID_IMM_LO];
        end
    end

    // Side effects, all but unpredictable gated by a passing condition
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            reg_write_en   <= 1'b0;
            flags_write_en <= 1'b0;
            mem_access_en  <= 1'b0;
            undef_trap     <= 1'b0;
            unpredictable  <= 1'b0;
        end else begin
            reg_write_en   <= instr_valid && next_pass && any_wr;
            flags_write_en <= instr_valid && next_fwe;
            mem_access_en  <= instr_valid && next_pass && any_mem;
            undef_trap     <= instr_valid && next_pass && c_und;
            unpredictable  <= instr_valid && c_unp;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking dcb @(posedge ref_clk); endclocking
    default disable iff (srst);

    chk_compact_latency: assert property (
        instr_valid && compact_state |=> dec_valid)
        else $error("compact word not decoded in one cycle");
    chk_flag_update: assert property (
        flags_write_en |-> cond_pass && expanded_word[`DID_SL_BIT] && $past(instr_valid))
        else $error("flags updated without set-flags bit");
    chk_cond_gate: assert property (
        !cond_pass |-> !reg_write_en && !flags_write_en && !mem_access_en)
        else $error("side effect on failed condition");
    chk_rot_imm: assert property (
        imm_operand |-> rotated_immediate ==
        (({24'h000000, expanded_word[7:0]} >> {expanded_word[11:8], 1'b0}) |
         ({24'h000000, expanded_word[7:0]} << (6'd32 - {1'b0, expanded_word[11:8], 1'b0}))))
        else $error("rotated immediate wrong");
    chk_user_xlate: assert property (
        user_translate |-> dec_class == DID_SINGLE && !expanded_word[`DID_P_BIT])
        else $error("user translation on pre-indexed word");
    chk_block_fields: assert property (
        instr_valid && !compact_state |=>
        block_transfer_control_bits == $past(instr_word[24:20]) &&
        reg_list == $past(instr_word[15:0]))
        else $error("block fields not taken from word");
    chk_swi_ignore: assert property (
        dec_class == DID_SWI |-> first_source_reg_field == 4'h0 &&
        dest_reg_field == 4'h0 && !mem_access_en)
        else $error("interrupt low bits leaked");
    chk_compact_regs: assert property (
        compact_state && !half_sel && (instr_word[15:11] == 5'b00100) |=>
        dest_reg_field == {1'b0, $past(instr_word[10:8])} && flags_write_en == $past(instr_valid))
        else $error("compact move lost its register");
    chk_unpred_notrap: assert property (
        unpredictable |-> !undef_trap && !mem_access_en)
        else $error("unpredictable form trapped");
    chk_cond_field: assert property (
        instr_valid && !compact_state |=> cond_field == $past(instr_word[31:28]))
        else $error("condition field misplaced");
endmodule
`default_nettype wire

/* File: did_decoder_test.sv */
// Self-checking bench for the dual instruction set decoder.
// Assumes did_pkg, did_decoder and did_imem_model are compiled first.
`default_nettype none
module did_decoder_test;
    timeunit 1ns;
    timeprecision 1ns;
    import did_pkg::*;

    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic ref_clk = 1'b0, srst = 1'b1, slow = 1'b0;
    logic instr_valid, half_sel, compact_state;
    logic [31:0] instr_word, expanded_word, rotated_immediate;
    logic [3:0] cond_flags = 4'h0, cond_field, opcode_field, first_source_reg_field;
    logic [3:0] dest_reg_field, coproc_reg_field, coproc_number_field;
    logic dec_valid, compact_unsupported, cond_pass, imm_operand, user_translate;
    logic reg_write_en, flags_write_en, mem_access_en, undef_trap, unpredictable;
    did_class_t dec_class;
    logic [4:0] block_transfer_control_bits;
    logic [15:0] reg_list;
    logic [7:0] coproc_offset;
    logic p_valid = 1'b0, p_half, p_comp;   // Inputs taken at last edge
    logic [31:0] p_word;
    logic [3:0] p_flags;
    int error_cnt = 0, checks = 0, seed;
    logic [31:0] tbl [0:19] = '{32'he3b01005, 32'he3a01005, 32'hf3b01005, 32'h03b01005,
        32'he0110392, 32'he0910392, 32'he1012092, 32'he12fff11, 32'he1c000d0,
        32'he1d000b0, 32'he4a01000, 32'he5a01000, 32'he7f000f0, 32'he8bd00ff,
        32'hea000010, 32'hed901205, 32'hee012003, 32'hee100f10, 32'hef123456,
        32'hef000000};

    always #25 ref_clk = ~ref_clk;

    did_imem_model mem (.ref_clk(ref_clk), .srst(srst), .slow(slow),
        .instr_valid(instr_valid), .instr_word(instr_word), .half_sel(half_sel),
        .compact_state(compact_state));

    did_decoder dut (.ref_clk(ref_clk), .srst(srst), .instr_valid(instr_valid),
        .instr_word(instr_word), .half_sel(half_sel), .compact_state(compact_state),
        .cond_flags(cond_flags), .dec_valid(dec_valid), .dec_class(dec_class),
        .expanded_word(expanded_word), .compact_unsupported(compact_unsupported),
        .cond_pass(cond_pass), .cond_field(cond_field), .opcode_field(opcode_field),
        .first_source_reg_field(first_source_reg_field), .dest_reg_field(dest_reg_field),
        .imm_operand(imm_operand), .rotated_immediate(rotated_immediate),
        .user_translate(user_translate),
        .block_transfer_control_bits(block_transfer_control_bits), .reg_list(reg_list),
        .coproc_reg_field(coproc_reg_field), .coproc_number_field(coproc_number_field),
        .coproc_offset(coproc_offset), .reg_write_en(reg_write_en),
        .flags_write_en(flags_write_en), .mem_access_en(mem_access_en),
        .undef_trap(undef_trap), .unpredictable(unpredictable));

    // ----------------------------------------
    // Reference model
    // ----------------------------------------
    // Class of a full-width word from its fixed bits
    function automatic did_class_t cls(input logic [31:0] w);
        case (w[27:25])
            3'b000: begin
                if (w[27:4] == 24'h12fff1) return DID_BX;
                if (w[7:4] == 4'h9) return w[24] ? DID_SWAP : (w[23] ? DID_MULL : DID_MUL);
                return (w[7] & w[4]) ? DID_HALF : DID_DP;
            end
            3'b001: return DID_DP;
            3'b010: return DID_SINGLE;
            3'b011: return w[4] ? DID_UNDEF : DID_SINGLE;
            3'b100: return DID_BLOCK;
            3'b101: return DID_BRANCH;
            3'b110: return DID_CPXFER;
            default: return w[24] ? DID_SWI : (w[4] ? DID_CPREG : DID_CPOP);
        endcase
    endfunction

    // Condition test against N,Z,C,V
    function automatic logic cpass(input logic [3:0] c, input logic [3:0] f);
        logic n, z, cy, v;
        {n, z, cy, v} = f;
        case (c)
            4'h0: return z;
            4'h1: return !z;
            4'h2: return cy;
            4'h3: return !cy;
            4'h4: return n;
            4'h5: return !n;
            4'h6: return v;
            4'h7: return !v;
            4'h8: return cy & !z;
            4'h9: return !cy | z;
            4'ha: return n == v;
            4'hb: return n != v;
            4'hc: return !z & (n == v);
            4'hd: return z | (n != v);
            4'he: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // Compare one output with its expected value
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // Capture what the decoder took at this edge
    always @(posedge ref_clk) begin
        p_valid <= instr_valid & ~srst;
        p_word  <= instr_word;
        p_half  <= half_sel;
        p_comp  <= compact_state;
        p_flags <= cond_flags;
        cond_flags <= 4'($urandom);
    end

    // Judge the result one edge after each word
    always @(negedge ref_clk) begin : judge
        logic [31:0] w;
        logic [15:0] h;
        logic [63:0] rr;
        logic uns, ok;
        logic [3:0] r8;
        did_class_t c;
        w = p_word;
        uns = 1'b0;
        h = p_half ? p_word[31:16] : p_word[15:0];
        if (p_comp) begin
            // Move, compare, add, subtract with eight-bit immediate
            r8 = {1'b0, h[10:8]};
            case (h[12:11])
                2'b00: w = {12'he3b, 4'h0, r8, 4'h0, h[7:0]};
                2'b01: w = {12'he35, r8, 8'h00, h[7:0]};
                2'b10: w = {12'he29, r8, r8, 4'h0, h[7:0]};
                default: w = {12'he25, r8, r8, 4'h0, h[7:0]};
            endcase
            // Three-operand add or subtract, register or small immediate
            if (h[15:11] == 5'b00011) w = {4'he, 2'b00, h[10], h[9] ? 5'b00101 : 5'b01001,
                1'b0, h[5:3], 1'b0, h[2:0], 9'h000, h[8:6]};
            // Software interrupt keeps only its low byte
            if (h[15:8] == 8'hdf) w = {24'hef0000, h[7:0]};
            uns = !(h[15:13] == 3'b001 || h[15:11] == 5'b00011 || h[15:8] == 8'hdf);
            if (uns) w = 32'he7f000f0;
        end
        c = cls(w);
        ok = cpass(w[31:28], p_flags);
        rr = {24'h0, w[7:0], 24'h0, w[7:0]} >> (2 * w[11:8]);
        chk(dec_valid, p_valid);
        if (!p_valid) begin
            chk({reg_write_en, flags_write_en, mem_access_en, undef_trap}, 0);
        end else begin
            chk(expanded_word, w);
            chk(compact_unsupported, uns);
            chk(dec_class, c);
            chk({cond_field, opcode_field}, {w[31:28], w[24:21]});
            chk(cond_pass, ok);
            chk(first_source_reg_field, c == DID_SWI ? 4'h0 : w[19:16]);
            chk(dest_reg_field, c == DID_SWI ? 4'h0 : w[15:12]);
            chk(imm_operand, c == DID_DP && w[25]);
            chk(rotated_immediate, rr[31:0]);
            chk(user_translate, c == DID_SINGLE && !w[24] && w[21]);
            chk({block_transfer_control_bits, reg_list}, {w[24:20], w[15:0]});
            chk({coproc_reg_field, coproc_number_field, coproc_offset}, w[15:0]);
            chk(flags_write_en, ok && w[20] && c inside {DID_DP, DID_MUL, DID_MULL});
            chk({undef_trap, unpredictable}, {ok && c == DID_UNDEF,
                c == DID_HALF && w[6] && !w[20]});
            if (c inside {DID_DP, DID_MUL, DID_BRANCH, DID_SWI}) chk(mem_access_en, 0);
            if (c inside {DID_SINGLE, DID_BLOCK, DID_SWAP}) chk(mem_access_en, ok);
            if (c == DID_HALF && w[6] && !w[20]) chk(mem_access_en, 0);
            if (!ok) chk(reg_write_en, 0);
            if (ok && c == DID_DP && w[24:23] != 2'b10) chk(reg_write_en, 1);
        end
    end

    // ----------------------------------------
    // Sequencing
    // ----------------------------------------
    task automatic complete_run();
        if (error_cnt == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Bounded wait until every queued word is decoded
    task automatic drain();
        int n;
        n = 0;
        while (mem.depth() != 0 && n < 5000) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 5000) begin
            error_cnt++;
            $display("BAD at %0t: fetch queue stuck", $time);
            complete_run();
        end else begin
            repeat (3) @(posedge ref_clk);
        end
    endtask

    initial begin
        seed = $urandom(32'hfebb);
        repeat (12) @(posedge ref_clk);
        srst <= 1'b0;
        // Every class back to back, compact words interleaved
        foreach (tbl[i]) mem.push(tbl[i], 1'b0, 1'b0);
        mem.push({16'he000, 16'h2305}, 1'b0, 1'b1);
        mem.push(32'he3b01005, 1'b0, 1'b0);
        mem.push({16'h27ff, 16'he000}, 1'b1, 1'b1);
        mem.push({16'h2305, 16'he000}, 1'b0, 1'b1);
        mem.push({16'h1a8a, 16'h1c8a}, 1'b0, 1'b1);
        mem.push({16'h1a8a, 16'hdf5a}, 1'b1, 1'b1);
        mem.push({16'h1a8a, 16'hdf5a}, 1'b0, 1'b1);
        drain();
        // Random immediates, conditions and compact immediate forms with gaps
        slow <= 1'b1;
        repeat (120) begin
            mem.push({4'($urandom), 3'b001, 25'($urandom)}, 1'b0, 1'b0);
            mem.push({3'b001, 13'($urandom), 3'b001, 13'($urandom)}, 1'($urandom), 1'b1);
        end
        drain();
        complete_run();
    end
endmodule
`default_nettype wire

/* File: did_imem_model.sv */
// Instruction memory model that feeds fetched words to the decoder.
// Assumes the bench queues words through push and clocks it on ref_clk.
`default_nettype none
module did_imem_model (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        srst,
    // Pacing: idle gaps between words when set
    input  wire logic        slow,
    // Fetch outputs
    output var logic         instr_valid,
    output var logic [31:0]  instr_word,
    output var logic         half_sel,
    output var logic         compact_state
);
    timeunit 1ns;
    timeprecision 1ns;

    // ----------------------------------------
    // Queue of fetches
    // ----------------------------------------
    logic [33:0] fifo [$];  // Queued {compact, half, word}
    logic [33:0] ent;       // Entry being sent
    int          gap;       // Idle cycles still to insert

    // Bench side: queue one fetch
    task automatic push(input logic [31:0] w, input logic h, input logic c);
        fifo.push_back({c, h, w});
    endtask

    // Words not yet taken by the decoder
    function automatic int depth();
        return fifo.size() + int'(instr_valid);
    endfunction

    // Quiet bus at time zero
    initial begin
        instr_valid   = 1'b0;
        instr_word    = 32'h00000000;
        half_sel      = 1'b0;
        compact_state = 1'b0;
        gap           = 0;
    end

    // ----------------------------------------
    // One word per cycle, gaps when slow
    // ----------------------------------------
    always @(posedge ref_clk) begin
        if (!srst && gap == 0 && fifo.size() > 0) begin
            ent = fifo.pop_front();
            instr_valid   <= 1'b1;
            instr_word    <= ent[31:0];
            half_sel      <= ent[32];
            compact_state <= ent[33];
            gap = slow ? int'($urandom_range(2, 0)) : 0;
        end else begin
            // Idle: valid dropped, bus word inverted each idle cycle
            if (gap > 0) gap = gap - 1;
            instr_valid <= 1'b0;
            instr_word  <= ~instr_word;
        end
    end
endmodule
`default_nettype wire

/* File: did_pkg.sv */
// Types shared by the dual instruction set decoder.
// Assumes nothing beyond the configuration header.
`default_nettype none
package did_pkg;
    // Instruction class of a full-width word
    typedef enum logic [3:0] {
        DID_DP     = 4'h0,
        DID_MUL    = 4'h1,
        DID_MULL   = 4'h2,
        DID_SWAP   = 4'h3,
        DID_BX     = 4'h4,
        DID_HALF   = 4'h5,
        DID_SINGLE = 4'h6,
        DID_UNDEF  = 4'h7,
        DID_BLOCK  = 4'h8,
        DID_BRANCH = 4'h9,
        DID_CPXFER = 4'ha,
        DID_CPOP   = 4'hb,
        DID_CPREG  = 4'hc,
        DID_SWI    = 4'hd
    } did_class_t;
    // Condition field codes
    typedef enum logic [3:0] {
        DID_EQ = 4'h0, DID_NE = 4'h1, DID_CS = 4'h2, DID_CC = 4'h3,
        DID_MI = 4'h4, DID_PL = 4'h5, DID_VS = 4'h6, DID_VC = 4'h7,
        DID_HI = 4'h8, DID_LS = 4'h9, DID_GE = 4'ha, DID_LT = 4'hb,
        DID_GT = 4'hc, DID_LE = 4'hd, DID_AL = 4'he, DID_NV = 4'hf
    } did_cond_t;
endpackage
`default_nettype wire
